//--- rtl/tic_top.v
// Operation
// [RULE1] Counter clock is one of seven prescaler rates or the external clock pin.
// [RULE2] Prescaler makes seven rates from bus clock; three-bit select picks one.
// [RULE3] Each channel keeps a 16-bit capture in high and low byte registers.
// [RULE4] Two edge select bits per channel choose which transition captures.
// [RULE5] Active edge copies the counter into channel registers and sets flag.
// [RULE6] Capture happens on every active edge, even with the flag already set.
// [RULE7] Interrupt request is high while a flag and its enable are both set.
// [RULE8] Software learns of captures by interrupt or by polling the flag.
// [RULE9] Software must read a capture before the next edge overwrites it.
// [RULE10] Reset leaves channel value registers untouched, so they start unknown.
// [RULE11] Capture and compare share one 16-bit modulo counter.
// [RULE12] Software should count counter overflows to extend measurement range.
// [RULE13] Flag clears by reading it set then writing zero; writing one does nothing. Code also clears it by writing one to its status bit.
//
// Added by the designer: strobed register access.
`timescale 1ns/1ps
`default_nettype none
`include "tic_defs.vh"

module tic_top
#(
  parameter NUM_CHAN = 6
)
(
  input wire clk_in,
  input wire rst_b_in,
  input wire [7:0] addr_in,
  input wire [7:0] wdata_in,
  input wire wr_in,
  input wire rd_in,
  output reg [7:0] rdata_out,
  input wire [NUM_CHAN-1:0] chan_pin_in,
  input wire ext_timer_clock_pin_in,
  output wire irq_out
);
  reg rst_s1_r;
  reg rst_s2_r;
  wire rst_b;

  reg [2:0] prescale_select_r;
  reg ovie_r;
  reg stop_r;
  reg ovf_r;
  reg ovf_arm_r;
  reg [15:0] count_r;
  reg [15:0] count_nxt;
  reg [15:0] mod_r;
  reg [7:0] mod_hi_buf_r;
  reg [7:0] cnt_lo_latch_r;
  reg [7:0] rdata_nxt;
  reg [7:0] tsc_view;
  reg [7:0] stat_view;
  reg [7:0] mask_view;
  localparam [7:0] RST_TSC = `TIC_RST_TSC;
  localparam [15:0] RST_MOD = `TIC_RST_MOD;

  wire tick;
  wire trst;
  wire wrap;
  wire tsc_wr;
  wire tsc_rd;
  wire stat_wr;
  wire mask_wr;
  wire ovf_clr;
  wire [NUM_CHAN-1:0] flags;
  wire [NUM_CHAN-1:0] ies;
  wire [NUM_CHAN-1:0] ch_hit;
  wire [8*NUM_CHAN-1:0] ch_rmux;
  wire cnth_rd;
  wire modh_wr;
  wire modl_wr;
  wire chan_irq;
  wire ovf_irq;

  // Reset release through two flops
  always @(posedge clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      rst_s1_r <= 1'b0;
      rst_s2_r <= 1'b0;
    end
    else
    begin
      rst_s1_r <= 1'b1;
      rst_s2_r <= rst_s1_r;
    end
  end
  assign rst_b = rst_s2_r;

  assign tsc_wr = wr_in & (addr_in == `TIC_A_TSC);
  assign tsc_rd = rd_in & (addr_in == `TIC_A_TSC);
  assign stat_wr = wr_in & (addr_in == `TIC_A_IRQ_STAT);
  assign mask_wr = wr_in & (addr_in == `TIC_A_IRQ_MASK);
  assign trst = tsc_wr & wdata_in[`TIC_TSC_TRST];
  assign cnth_rd = rd_in & (addr_in == `TIC_A_CNTH);
  assign modh_wr = wr_in & (addr_in == `TIC_A_MODH);
  assign modl_wr = wr_in & (addr_in == `TIC_A_MODL);

  tic_prescaler u_prescaler
  (
    .clk_in(clk_in),
    .rst_b_in(rst_b),
    .prescale_select_in(prescale_select_r),
    .stop_in(stop_r),
    .clr_in(trst),
    .ext_timer_clock_pin_in(ext_timer_clock_pin_in),
    .tick_out(tick)
  );

  // Timer status and control
  always @(posedge clk_in or negedge rst_b)
  begin
    if (!rst_b)
    begin
      prescale_select_r <= RST_TSC[`TIC_TSC_PS_HI:`TIC_TSC_PS_LO];
      ovie_r <= RST_TSC[`TIC_TSC_OVIE];
      stop_r <= RST_TSC[`TIC_TSC_STOP];
    end
    else if (tsc_wr)
    begin
      prescale_select_r <= wdata_in[`TIC_TSC_PS_HI:`TIC_TSC_PS_LO]; // [RULE2]
      ovie_r <= wdata_in[`TIC_TSC_OVIE];
      stop_r <= wdata_in[`TIC_TSC_STOP];
    end
    // Mask bit 7 is a second view of the overflow enable
    else if (mask_wr)
      ovie_r <= wdata_in[`TIC_IRQ_OVF_BIT];
  end

  // Free-running modulo counter shared by all channels
  assign wrap = tick & (count_r == mod_r);

  always @*
  begin
    count_nxt = count_r;
    if (trst)
      count_nxt = `TIC_RST_CNT;
    else if (wrap)
      count_nxt = `TIC_RST_CNT; // [RULE11]
    else if (tick)
      count_nxt = count_r + 16'h0001; // [RULE1] [RULE11]
  end

  always @(posedge clk_in or negedge rst_b)
  begin
    if (!rst_b)
      count_r <= `TIC_RST_CNT;
    else
      count_r <= count_nxt;
  end

  // Modulo value: high byte is held until the low byte write
  always @(posedge clk_in or negedge rst_b)
  begin
    if (!rst_b)
    begin
      mod_r <= RST_MOD;
      mod_hi_buf_r <= RST_MOD[15:8];
    end
    else
    begin
      if (modh_wr)
        mod_hi_buf_r <= wdata_in;
      if (modl_wr)
        mod_r <= {mod_hi_buf_r, wdata_in};
    end
  end

  // Counter high read latches the low byte for a coherent pair
  always @(posedge clk_in or negedge rst_b)
  begin
    if (!rst_b)
      cnt_lo_latch_r <= 8'h00;
    else if (cnth_rd)
      cnt_lo_latch_r <= count_r[7:0];
  end

  // Overflow flag, cleared like a channel flag or by write-one at status
  assign ovf_clr = (tsc_wr & ovf_arm_r & ~wdata_in[`TIC_TSC_OVF]) |
    (stat_wr & wdata_in[`TIC_IRQ_OVF_BIT]);

  always @(posedge clk_in or negedge rst_b)
  begin
    if (!rst_b)
    begin
      ovf_r <= 1'b0;
      ovf_arm_r <= 1'b0;
    end
    else
    begin
      if (wrap)
        ovf_r <= 1'b1;
      else if (ovf_clr)
        ovf_r <= 1'b0;
      if (tsc_rd && ovf_r)
        ovf_arm_r <= 1'b1;
      else if (tsc_wr || !ovf_r)
        ovf_arm_r <= 1'b0;
    end
  end

  // Capture channels
  genvar i;
  generate
    for (i = 0; i < NUM_CHAN; i = i + 1)
    begin : g_chan
      localparam integer A_SC_I = `TIC_A_CH_BASE + i * `TIC_CH_STRIDE;
      localparam [7:0] A_SC = A_SC_I[7:0];
      localparam [7:0] A_HI = A_SC + 8'h01;
      localparam [7:0] A_LO = A_SC + 8'h02;
      wire [7:0] csc;
      wire [7:0] hi;
      wire [7:0] lo;
      wire sc_hit;
      wire hi_hit;
      wire lo_hit;

      assign sc_hit = (addr_in == A_SC);
      assign hi_hit = (addr_in == A_HI);
      assign lo_hit = (addr_in == A_LO);
      assign ch_hit[i] = sc_hit | hi_hit | lo_hit;
      assign ch_rmux[8*i +: 8] = sc_hit ? csc : (hi_hit ? hi : (lo_hit ? lo : 8'h00));

      tic_capture_chan #(.HAS_MSB((i % 2) == 0)) u_chan
      (
        .clk_in(clk_in),
        .rst_b_in(rst_b),
        .pin_in(chan_pin_in[i]),
        .count_in(count_r), // [RULE11]
        .csc_wr_in(wr_in & sc_hit),
        .csc_rd_in(rd_in & sc_hit),
        .hi_wr_in(wr_in & hi_hit),
        .lo_wr_in(wr_in & lo_hit),
        .wdata_in(wdata_in),
        .flag_w1c_in(stat_wr & wdata_in[i]),
        .ie_wr_in(mask_wr),
        .ie_val_in(wdata_in[i]),
        .flag_out(flags[i]),
        .irq_en_out(ies[i]),
        .csc_out(csc),
        .hi_out(hi),
        .lo_out(lo)
      );
    end
  endgenerate

  // Register views built from field positions; counter reset reads 0
  always @*
  begin
    tsc_view = 8'h00;
    tsc_view[`TIC_TSC_OVF] = ovf_r;
    tsc_view[`TIC_TSC_OVIE] = ovie_r;
    tsc_view[`TIC_TSC_STOP] = stop_r;
    tsc_view[`TIC_TSC_PS_HI:`TIC_TSC_PS_LO] = prescale_select_r;
    stat_view = 8'h00;
    stat_view[NUM_CHAN-1:0] = flags;
    stat_view[`TIC_IRQ_OVF_BIT] = ovf_r;
    mask_view = 8'h00;
    mask_view[NUM_CHAN-1:0] = ies;
    mask_view[`TIC_IRQ_OVF_BIT] = ovie_r;
  end

  // Read mux, answered one cycle after the strobe
  integer k;
  always @*
  begin
    rdata_nxt = 8'h00;
    case (addr_in)
      `TIC_A_TSC: rdata_nxt = tsc_view;
      `TIC_A_CNTH: rdata_nxt = count_r[15:8];
      `TIC_A_CNTL: rdata_nxt = cnt_lo_latch_r;
      `TIC_A_MODH: rdata_nxt = mod_r[15:8];
      `TIC_A_MODL: rdata_nxt = mod_r[7:0];
      `TIC_A_IRQ_STAT: rdata_nxt = stat_view;
      `TIC_A_IRQ_MASK: rdata_nxt = mask_view;
      default:
      begin
        for (k = 0; k < NUM_CHAN; k = k + 1)
          if (ch_hit[k])
            rdata_nxt = ch_rmux[8*k +: 8];
      end
    endcase
  end

  always @(posedge clk_in or negedge rst_b)
  begin
    if (!rst_b)
      rdata_out <= 8'h00;
    else if (rd_in)
      rdata_out <= rdata_nxt;
    else
      rdata_out <= 8'h00;
  end

  // Interrupt: any set flag whose enable is set
  assign chan_irq = |(flags & ies); // [RULE7]
  assign ovf_irq = ovf_r & ovie_r;
  assign irq_out = chan_irq | ovf_irq; // [RULE7]
endmodule
`default_nettype wire

//--- rtl/tic_defs.vh
`ifndef TIC_DEFS_VH
`define TIC_DEFS_VH

// Register offsets
`define TIC_A_TSC 8'h20
`define TIC_A_CNTH 8'h21
`define TIC_A_CNTL 8'h22
`define TIC_A_MODH 8'h23
`define TIC_A_MODL 8'h24
`define TIC_A_CH_BASE 8'h26
`define TIC_CH_STRIDE 3
`define TIC_A_CH4L 8'h34
`define TIC_A_CH5SC 8'h35
`define TIC_A_CH5H 8'h36
`define TIC_A_CH5L 8'h37
`define TIC_A_IRQ_STAT 8'h38
`define TIC_A_IRQ_MASK 8'h39

// Timer status and control fields
`define TIC_TSC_OVF 7
`define TIC_TSC_OVIE 6
`define TIC_TSC_STOP 5
`define TIC_TSC_TRST 4
`define TIC_TSC_PS_HI 2
`define TIC_TSC_PS_LO 0
`define TIC_PS_EXT 3'h7

// Channel status and control fields
`define TIC_CSC_FLAG 7
`define TIC_CSC_IE 6
`define TIC_CSC_MSB 5
`define TIC_CSC_MSA 4
`define TIC_CSC_ELSB 3
`define TIC_CSC_ELSA 2
`define TIC_CSC_TOV 1
`define TIC_CSC_MAX 0

// Edge select codes {edge_level_sel_hi, edge_level_sel_lo}
`define TIC_EDGE_OFF 2'h0
`define TIC_EDGE_RISE 2'h1
`define TIC_EDGE_FALL 2'h2
`define TIC_EDGE_BOTH 2'h3

// Interrupt status bit of the overflow event
`define TIC_IRQ_OVF_BIT 7

// Reset values
`define TIC_RST_TSC 8'h00
`define TIC_RST_CSC 8'h00
`define TIC_RST_MOD 16'hffff
`define TIC_RST_CNT 16'h0000

`endif

//--- rtl/tic_prescaler.v
`timescale 1ns/1ps
`default_nettype none
`include "tic_defs.vh"

module tic_prescaler
(
  input wire clk_in,
  input wire rst_b_in,
  input wire [2:0] prescale_select_in,
  input wire stop_in,
  input wire clr_in,
  input wire ext_timer_clock_pin_in,
  output reg tick_out
);
  reg [5:0] div_r;
  reg ext_prev_r;
  reg [5:0] mask;
  wire ext_rise;

  assign ext_rise = ext_timer_clock_pin_in & ~ext_prev_r;

  // Divide by 1, 2, 4 .. 64 for selects 0 to 6
  always @*
  begin
    case (prescale_select_in)
      3'h0: mask = 6'h00;
      3'h1: mask = 6'h01;
      3'h2: mask = 6'h03;
      3'h3: mask = 6'h07;
      3'h4: mask = 6'h0f;
      3'h5: mask = 6'h1f;
      3'h6: mask = 6'h3f;
      default: mask = 6'h00;
    endcase
  end

  always @(posedge clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      div_r <= 6'h00;
      ext_prev_r <= 1'b0;
      tick_out <= 1'b0;
    end
    else
    begin
      ext_prev_r <= ext_timer_clock_pin_in;
      if (clr_in || stop_in)
      begin
        div_r <= 6'h00;
        tick_out <= 1'b0;
      end
      else
      begin
        div_r <= div_r + 6'h01; // [RULE2]
        if (prescale_select_in == `TIC_PS_EXT)
          tick_out <= ext_rise; // [RULE1]
        else
          tick_out <= ((div_r & mask) == mask); // [RULE1] [RULE2]
      end
    end
  end
endmodule
`default_nettype wire

//--- rtl/tic_capture_chan.v
`timescale 1ns/1ps
`default_nettype none
`include "tic_defs.vh"

module tic_capture_chan
#(
  parameter HAS_MSB = 0
)
(
  input wire clk_in,
  input wire rst_b_in,
  input wire pin_in,
  input wire [15:0] count_in,
  input wire csc_wr_in,
  input wire csc_rd_in,
  input wire hi_wr_in,
  input wire lo_wr_in,
  input wire [7:0] wdata_in,
  input wire flag_w1c_in,
  input wire ie_wr_in,
  input wire ie_val_in,
  output reg flag_out,
  output wire irq_en_out,
  output wire [7:0] csc_out,
  output reg [7:0] hi_out,
  output reg [7:0] lo_out
);
  reg [6:0] ctl_r;
  reg arm_r;
  reg pin_prev_r;
  wire [1:0] edge_sel;
  wire rise;
  wire fall;
  wire cap;
  wire sw_clr;
  localparam [7:0] RST_CSC = `TIC_RST_CSC;

  assign edge_sel = {ctl_r[`TIC_CSC_ELSB], ctl_r[`TIC_CSC_ELSA]};
  assign rise = pin_in & ~pin_prev_r;
  assign fall = ~pin_in & pin_prev_r;
  // Capture only in input capture mode
  assign cap = ~ctl_r[`TIC_CSC_MSA] & ~ctl_r[`TIC_CSC_MSB] &
    (((edge_sel == `TIC_EDGE_RISE) & rise) | ((edge_sel == `TIC_EDGE_FALL) & fall) |
    ((edge_sel == `TIC_EDGE_BOTH) & (rise | fall))); // [RULE4]
  assign sw_clr = (csc_wr_in & arm_r & ~wdata_in[`TIC_CSC_FLAG]) | flag_w1c_in; // [RULE13]
  assign irq_en_out = ctl_r[`TIC_CSC_IE];
  assign csc_out = {flag_out, ctl_r};

  always @(posedge clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      ctl_r <= RST_CSC[6:0];
      flag_out <= 1'b0;
      arm_r <= 1'b0;
      pin_prev_r <= 1'b0;
    end
    else
    begin
      pin_prev_r <= pin_in;
      if (csc_wr_in)
      begin
        ctl_r <= wdata_in[6:0];
        if (HAS_MSB == 0)
          ctl_r[`TIC_CSC_MSB] <= 1'b0;
      end
      else if (ie_wr_in)
        ctl_r[`TIC_CSC_IE] <= ie_val_in;
      // Set wins over any clear in the same cycle
      if (cap)
        flag_out <= 1'b1; // [RULE5]
      else if (sw_clr)
        flag_out <= 1'b0; // [RULE13]
      if (csc_rd_in && flag_out)
        arm_r <= 1'b1; // [RULE13]
      else if (csc_wr_in || !flag_out)
        arm_r <= 1'b0;
    end
  end

  // No reset on captured values: contents survive reset
  always @(posedge clk_in)
  begin
    if (cap)
    begin
      hi_out <= count_in[15:8]; // [RULE3] [RULE5] [RULE6] [RULE10]
      lo_out <= count_in[7:0]; // [RULE3] [RULE5] [RULE6]
    end
    else
    begin
      if (hi_wr_in)
        hi_out <= wdata_in;
      if (lo_wr_in)
        lo_out <= wdata_in;
    end
  end
endmodule
`default_nettype wire

//--- dv/tic_top_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module tic_top_monitor #(parameter NUM_CHAN = 6) (
  input wire logic clk_in,
  input wire logic rst_b_in,
  input wire logic [7:0] addr_in,
  input wire logic [7:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  input wire logic [7:0] rdata_out,
  input wire logic [NUM_CHAN-1:0] chan_pin_in,
  input wire logic ext_timer_clock_pin_in,
  input wire logic irq_out
);
  // Shadow of channel 5 control; its enable is also reachable through the mask
  logic [7:0] cfg5_r;
  always @(posedge clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
      cfg5_r <= 8'h00;
    else if (wr_in && addr_in == 8'h35)
      cfg5_r <= wdata_in;
    else if (wr_in && addr_in == 8'h39)
      cfg5_r[6] <= wdata_in[5];
  end
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!rst_b_in);
  property p_rd_idle;
    !rd_in |=> rdata_out == 8'h00;
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data outside answer");
  property p_unmapped;
    rd_in && addr_in == 8'h3a |=> rdata_out == 8'h00;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  property p_irq_rst;
    $rose(rst_b_in) |-> !irq_out [*3];
  endproperty
  a_irq_rst: assert property (p_irq_rst) else $error("irq after reset");
  property p_mask_zero;
    wr_in && addr_in == 8'h39 && wdata_in == 8'h00 |=> !irq_out;
  endproperty
  a_mask_zero: assert property (p_mask_zero) else $error("irq with mask off");
  property p_mask_rb;
    wr_in && addr_in == 8'h39 ##1 rd_in && addr_in == 8'h39
      |=> (rdata_out & 8'hbf) == ($past(wdata_in, 2) & 8'hbf);
  endproperty
  a_mask_rb: assert property (p_mask_rb) else $error("mask readback");
  property p_ch5_rb;
    wr_in && addr_in == 8'h35 ##1 rd_in && addr_in == 8'h35
      |=> (rdata_out & 8'h7f) == ($past(wdata_in, 2) & 8'h5f);
  endproperty
  a_ch5_rb: assert property (p_ch5_rb) else $error("status readback");
  property p_hi_rb;
    wr_in && addr_in == 8'h36 && cfg5_r[3:2] == 2'h0 ##1 rd_in && addr_in == 8'h36
      |=> rdata_out == $past(wdata_in, 2);
  endproperty
  a_hi_rb: assert property (p_hi_rb) else $error("high byte readback");
  property p_cap_irq;
    cfg5_r[6] && cfg5_r[4] == 1'b0 && (cfg5_r[2] && $rose(chan_pin_in[5])
      || cfg5_r[3] && $fell(chan_pin_in[5])) |-> ##[1:3] irq_out;
  endproperty
  a_cap_irq: assert property (p_cap_irq) else $error("no irq on edge");
endmodule
`default_nettype wire

//--- dv/tic_pin_model.sv
`timescale 1ns/1ps
`default_nettype none
module tic_pin_model (
  input wire logic clk_in,
  input wire logic ext_en_in,
  output logic [5:0] pin_out,
  output logic ext_out
);
  logic ph_r = 1'b0;
  initial
  begin
    pin_out = 6'h00;
    ext_out = 1'b0;
  end
  // External counter clock: one rising edge every four cycles while enabled
  always @(posedge clk_in)
  begin
    ph_r <= ~ph_r;
    if (ext_en_in && ph_r)
      ext_out <= ~ext_out;
  end
  task automatic set(input int ch, input logic v);
    @(posedge clk_in);
    pin_out[ch] <= v;
  endtask
  // Two rising edges exactly gap cycles apart, low pulse between
  task automatic edge_pair(input int ch, input int gap);
    set(ch, 1'b0);
    repeat (4) @(posedge clk_in);
    set(ch, 1'b1);
    repeat (7) @(posedge clk_in);
    set(ch, 1'b0);
    repeat (gap - 9) @(posedge clk_in);
    set(ch, 1'b1);
  endtask
  task automatic noise(input logic [4:0] v);
    @(posedge clk_in);
    pin_out[4:0] <= v;
  endtask
endmodule
`default_nettype wire

//--- dv/tic_top_tb.sv
`timescale 1ns/1ps
`default_nettype none
module tic_top_tb;
  logic clk_in = 1'b0, rst_b_in = 1'b0, wr_in = 1'b0, rd_in = 1'b0, ext_en = 1'b0, rd_d = 1'b0;
  logic [7:0] addr_in = 8'h00, wdata_in = 8'h00, got_r, d, a;
  logic [15:0] c1, c2;
  logic [15:0] exp_q[$];
  wire logic [7:0] rdata_out;
  wire logic irq_out, ext_pin;
  wire logic [5:0] pins;
  int errors = 0, n_checks = 0, seed = 32'hc391;

  always #2.5 clk_in = ~clk_in;

  tic_top dut_u (.clk_in(clk_in), .rst_b_in(rst_b_in), .addr_in(addr_in), .wdata_in(wdata_in),
    .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out), .chan_pin_in(pins),
    .ext_timer_clock_pin_in(ext_pin), .irq_out(irq_out));
  tic_pin_model pin_u (.clk_in(clk_in), .ext_en_in(ext_en), .pin_out(pins), .ext_out(ext_pin));

  task note(input logic ok, input logic [15:0] got, input logic [15:0] e);
    n_checks++;
    if (!ok)
    begin
      errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, e);
    end
  endtask
  task chk_rd(input logic [7:0] got, input logic [15:0] e);
    note((got & e[15:8]) === (e[7:0] & e[15:8]), {8'h00, got}, e);
  endtask
  task chk_irq(input logic e);
    note(irq_out === e, {15'h0, irq_out}, {15'h0, e});
  endtask
  task chk_val(input logic [15:0] got, input logic [15:0] e);
    note(got === e, got, e);
  endtask

  // Read data stand only in the cycle after the strobe
  always @(posedge clk_in)
  begin
    rd_d <= rd_in;
    if (rd_d)
    begin
      got_r = rdata_out;
      chk_rd(rdata_out, exp_q.pop_front());
    end
  end

  task bus(input logic [7:0] ad, input logic [7:0] dd, input logic w, input logic r);
    @(posedge clk_in);
    addr_in <= ad;
    wdata_in <= dd;
    wr_in <= w;
    rd_in <= r;
  endtask
  task wr(input logic [7:0] ad, input logic [7:0] dd);
    bus(ad, dd, 1'b1, 1'b0);
  endtask
  task wt(input int n);
    bus(addr_in, 8'h00, 1'b0, 1'b0);
    repeat (n - 1) @(posedge clk_in);
  endtask
  task rd(input logic [7:0] ad, input logic [15:0] e);
    bus(ad, 8'h00, 1'b0, 1'b1);
    exp_q.push_back(e);
    wt(2);
    #1;
  endtask
  task pin(input logic v);
    wt(1);
    pin_u.set(5, v);
    wt(4);
  endtask

  task finish_test;
    $display("errors=%0d checks=%0d", errors, n_checks);
    if (errors == 0 && n_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  initial
  begin
    #100000;
    errors++;
    finish_test;
  end

  initial
  begin
    repeat (12) @(posedge clk_in);
    rst_b_in <= 1'b1;
    repeat (3) @(posedge clk_in);
    rd(8'h35, 16'hff00);
    rd(8'h20, 16'hff00);
    rd(8'h3a, 16'hff00);
    for (int i = 0; i < 6; i++)
    begin
      d = 8'($random(seed));
      a = i % 3 == 0 ? 8'h34 : 8'(8'h35 + i % 3);
      wr(a, d);
      rd(a, {8'hff, d});
    end
    d = 8'($random(seed)) & 8'h5f;
    wr(8'h35, d);
    rd(8'h35, {8'h7f, d});
    wr(8'h39, 8'ha0);
    rd(8'h39, 16'hbfa0);
    wr(8'h39, 8'h00);
    for (int ps = 0; ps < 8; ps++)
    begin
      ext_en <= (ps == 7);
      pin_u.noise(5'($random(seed)));
      wr(8'h20, 8'(8'h10 | ps));
      wr(8'h38, 8'h20);
      wr(8'h35, 8'h44);
      wt(1);
      fork
        pin_u.edge_pair(5, 128);
        begin
          wt(30);
          rd(8'h36, 16'h0000);
          c1[15:8] = got_r;
          rd(8'h37, 16'h0000);
          c1[7:0] = got_r;
          rd(8'h35, 16'h8080);
          chk_irq(1'b1);
        end
      join
      wt(4);
      rd(8'h36, 16'h0000);
      c2[15:8] = got_r;
      rd(8'h37, 16'h0000);
      c2[7:0] = got_r;
      chk_val(c2 - c1, ps == 7 ? 16'd32 : 16'(128 >> ps));
    end
    wr(8'h23, 8'h00);
    wr(8'h24, 8'h0f);
    wr(8'h20, 8'h10);
    wt(40);
    rd(8'h38, 16'h8080);
    rd(8'h24, 16'hff0f);
    wr(8'h20, 8'h20);
    wt(3);
    wr(8'h38, 8'h80);
    rd(8'h38, 16'h8000);
    rd(8'h20, 16'hff20);
    wr(8'h38, 8'h20);
    for (int e = 0; e < 4; e++)
    begin
      d = 8'(8'h40 | (e << 2));
      wr(8'h35, d);
      pin(1'b1);
      rd(8'h35, {8'h80, e[0] ? 8'h80 : 8'h00});
      chk_irq(e[0]);
      wr(8'h35, 8'h80 | d);
      rd(8'h35, {8'h80, e[0] ? 8'h80 : 8'h00});
      wr(8'h35, d);
      rd(8'h35, 16'h8000);
      pin(1'b0);
      rd(8'h35, {8'h80, e[1] ? 8'h80 : 8'h00});
      wr(8'h38, 8'h20);
      rd(8'h35, 16'h8000);
      chk_irq(1'b0);
    end
    wr(8'h39, 8'h00);
    wt(2);
    finish_test;
  end
endmodule

bind tic_top tic_top_monitor #(.NUM_CHAN(NUM_CHAN)) mon_u (.clk_in(clk_in),
  .rst_b_in(rst_b_in), .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in),
  .rd_in(rd_in), .rdata_out(rdata_out), .chan_pin_in(chan_pin_in),
  .ext_timer_clock_pin_in(ext_timer_clock_pin_in), .irq_out(irq_out));
`default_nettype wire
